/* File: hw/scan_timer_pkg.sv */
// Package with constants and carrier types for the periodic scan interrupt timer
package scan_timer_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [16:0] TICK_RELOAD = 17'(TICK_CYCLES - 1);
  localparam logic [13:0] IRQ0_MIN_MS = 14'h0005;
  localparam logic [13:0] IRQ0_MAX_MS = 14'h03e7;
  localparam logic [13:0] IRQ1_MIN_MS = 14'h0005;
  localparam logic [13:0] IRQ1_MAX_MS = 14'h270f;
  localparam logic [6:0] FILTER_MAX_MS = 7'h63;
  localparam logic [6:0] FILTER_DEFAULT_MS = 7'h0a;
  localparam logic [13:0] COUNT_RESET = 14'h0000;

  typedef enum logic [1:0] {
    SCAN_RUN = 2'b00,
    SCAN_IRQ0 = 2'b01,
    SCAN_IRQ1 = 2'b10
  } scan_state_e;

  typedef struct packed {
    logic periodic_zero_en;
    logic periodic_one_en;
    logic ext_irq_en;
    logic [13:0] interval_zero_ms;
    logic [13:0] interval_one_ms;
    logic [6:0] filter_one_ms;
  } timer_cfg_s;

  typedef struct packed {
    logic vector_valid;
    logic [1:0] vector;
    logic [15:0] resume_addr;
  } dispatch_s;
endpackage

/* File: hw/interval_counter.sv */
// One periodic interval counter stepped by the 1 ms tick
`timescale 1ns/10ps
module interval_counter
  import scan_timer_pkg::*;
#(
  parameter logic [13:0] MAX_MS = 14'h03e7
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tick,
  input wire logic enable,
  input wire logic [13:0] interval_ms,
  output logic expire
);
  logic [13:0] count_reg;
  logic [13:0] load_val;

  // Clamp to the legal window
  always_comb begin
    if (interval_ms < IRQ0_MIN_MS) begin
      load_val = IRQ0_MIN_MS;
    end else if (interval_ms > MAX_MS) begin
      load_val = MAX_MS;
    end else begin
      load_val = interval_ms;
    end
  end

  // Down counter reloads on expiry
  always_ff @(posedge mclk) begin
    if (rst || !enable) begin
      count_reg <= COUNT_RESET;
      expire <= 1'b0;
    end else if (tick) begin
      if (count_reg <= 14'h0001) begin
        count_reg <= load_val;
        expire <= (count_reg == 14'h0001);
      end else begin
        count_reg <= count_reg - 14'h0001;
        expire <= 1'b0;
      end
    end else begin
      expire <= 1'b0;
    end
  end
endmodule // interval_counter

/* File: hw/periodic_scan_interrupt_timer.sv */
// Top of the periodic scan interrupt timer with scan dispatch and input filter
// Overview of operation
// - Timer zero interval runs from 5 ms to 999 ms, interrupting each expiry.
// - Timer one, on two-timer variant, runs from 5 ms to 9999 ms.
// - Intervals count in whole 1 ms ticks.
// - Timers repeat cyclically with no external trigger.
// - Expiry suspends the scan and dispatches the timer's interrupt routine.
// - Routine completion resumes the scan at the suspended address.
// - Single-timer variant: external interrupt and timer zero share one routine, one enabled.
// - Two-timer variant lets external interrupt and a periodic timer coexist.
// - With periodic interrupts, fast input zero is filtered using input one's time.
// - Filter time programmable 0 to 99 ms, default 10 ms.
// - External mode: edge on fast input zero triggers the shared routine.
`timescale 1ns/10ps
module periodic_scan_interrupt_timer
  import scan_timer_pkg::*;
#(
  parameter bit TWO_TIMERS = 1'b1,
  parameter logic [16:0] TICK_DIV = TICK_RELOAD
) (
  input wire logic mclk,
  input wire logic rst,
  input timer_cfg_s cfg,
  input wire logic fast_input_zero,
  input wire logic [15:0] ladder_program_addr,
  input wire logic routine_done,
  output logic scan_hold,
  output dispatch_s dispatch,
  output logic periodic_irq_zero,
  output logic periodic_irq_one,
  output logic fast_input_zero_filtered,
  output logic cfg_conflict
);
  // ==========================================================
  // Prescaler
  logic [16:0] pre_reg;
  logic tick;

  always_ff @(posedge mclk) begin
    if (rst || pre_reg == 17'h00000) begin
      pre_reg <= TICK_DIV;
    end else begin
      pre_reg <= pre_reg - 17'h00001;
    end
  end

  assign tick = (pre_reg == 17'h00000);

  // ==========================================================
  // Input synchroniser and edge
  logic in_meta_reg;
  logic in_sync_reg;
  logic in_prev_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      in_meta_reg <= 1'b0;
      in_sync_reg <= 1'b0;
      in_prev_reg <= 1'b0;
    end else begin
      in_meta_reg <= fast_input_zero;
      in_sync_reg <= in_meta_reg;
      in_prev_reg <= in_sync_reg;
    end
  end

  // ==========================================================
  // Mode selection
  logic single_ext;
  logic zero_en;
  logic one_en;
  logic ext_en;

  // Single-timer: external mode wins, timer zero held off
  assign single_ext = !TWO_TIMERS && cfg.ext_irq_en;
  assign zero_en = cfg.periodic_zero_en && !single_ext;
  assign one_en = TWO_TIMERS && cfg.periodic_one_en;
  assign ext_en = cfg.ext_irq_en;

  // ==========================================================
  // Configuration check
  logic conflict_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      conflict_reg <= 1'b0;
    end else begin
      conflict_reg <= !TWO_TIMERS && cfg.ext_irq_en && cfg.periodic_zero_en;
    end
  end

  assign cfg_conflict = conflict_reg;

  // ==========================================================
  // Interval counters
  logic exp_zero;
  logic exp_one;

  interval_counter #(.MAX_MS(IRQ0_MAX_MS)) u_zero (
    .mclk(mclk),
    .rst(rst),
    .tick(tick),
    .enable(zero_en),
    .interval_ms(cfg.interval_zero_ms),
    .expire(exp_zero)
  );

  interval_counter #(.MAX_MS(IRQ1_MAX_MS)) u_one (
    .mclk(mclk),
    .rst(rst),
    .tick(tick),
    .enable(one_en),
    .interval_ms(cfg.interval_one_ms),
    .expire(exp_one)
  );

  // ==========================================================
  // External interrupt edge
  logic ext_edge;
  assign ext_edge = ext_en && in_sync_reg && !in_prev_reg;

  // ==========================================================
  // Interrupt request outputs
  assign periodic_irq_zero = exp_zero;
  assign periodic_irq_one = exp_one;

  // ==========================================================
  // Pending requests, set wins over clear
  logic pend_zero_reg;
  logic pend_one_reg;
  scan_state_e state_reg;
  logic take_zero;
  logic take_one;

  assign take_zero = state_reg == SCAN_RUN && pend_zero_reg;
  assign take_one = state_reg == SCAN_RUN && !pend_zero_reg && pend_one_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_zero_reg <= 1'b0;
      pend_one_reg <= 1'b0;
    end else begin
      pend_zero_reg <= (exp_zero || ext_edge) || (pend_zero_reg && !take_zero);
      pend_one_reg <= exp_one || (pend_one_reg && !take_one);
    end
  end

  // ==========================================================
  // Scan suspend and resume
  logic [15:0] resume_reg;
  logic [1:0] vec_reg;
  logic valid_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= SCAN_RUN;
      resume_reg <= 16'h0000;
      vec_reg <= 2'h0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      case (state_reg)
        SCAN_RUN: begin
          if (take_zero) begin
            state_reg <= SCAN_IRQ0;
            resume_reg <= ladder_program_addr;
            vec_reg <= 2'h0;
            valid_reg <= 1'b1;
          end else if (take_one) begin
            state_reg <= SCAN_IRQ1;
            resume_reg <= ladder_program_addr;
            vec_reg <= 2'h1;
            valid_reg <= 1'b1;
          end
        end
        default: begin
          if (routine_done) begin
            state_reg <= SCAN_RUN;
          end
        end
      endcase
    end
  end

  assign scan_hold = state_reg != SCAN_RUN;
  assign dispatch = '{vector_valid: valid_reg, vector: vec_reg, resume_addr: resume_reg};

  // ==========================================================
  // Input filter for fast input zero
  logic [6:0] filt_ms_reg;
  logic [6:0] filt_cnt_reg;
  logic filt_out_reg;

  // Filter time, default until configuration is taken
  always_ff @(posedge mclk) begin
    if (rst) begin
      filt_ms_reg <= FILTER_DEFAULT_MS;
    end else if (cfg.filter_one_ms > FILTER_MAX_MS) begin
      filt_ms_reg <= FILTER_MAX_MS;
    end else begin
      filt_ms_reg <= cfg.filter_one_ms;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      filt_cnt_reg <= 7'h00;
      filt_out_reg <= 1'b0;
    end else if (in_sync_reg == filt_out_reg) begin
      filt_cnt_reg <= 7'h00;
    end else if (filt_cnt_reg >= filt_ms_reg) begin
      filt_out_reg <= in_sync_reg;
      filt_cnt_reg <= 7'h00;
    end else if (tick) begin
      filt_cnt_reg <= filt_cnt_reg + 7'h01;
    end
  end

  assign fast_input_zero_filtered = filt_out_reg;
endmodule // periodic_scan_interrupt_timer

/* File: tb/scan_timer_monitor.sv */
// Checker for the periodic scan interrupt timer
`timescale 1ns/10ps
module scan_timer_monitor
  import scan_timer_pkg::*;
#(
  parameter bit TWO_TIMERS = 1'b1,
  parameter logic [16:0] TICK_DIV = TICK_RELOAD
) (
  input wire logic mclk,
  input wire logic rst,
  input timer_cfg_s cfg,
  input wire logic routine_done,
  input wire logic scan_hold,
  input dispatch_s dispatch,
  input wire logic periodic_irq_zero,
  input wire logic periodic_irq_one,
  input wire logic cfg_conflict
);
  // ====
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence irq_idle_s; periodic_irq_zero && !scan_hold; endsequence
  sequence go_s; ##[1:3] dispatch.vector_valid; endsequence
  sequence clash_held_s; cfg_conflict && $past(cfg_conflict); endsequence
  irq0_pulse_a: assert property (periodic_irq_zero |=> !periodic_irq_zero)
    else $error("irq0 wide");
  irq1_pulse_a: assert property (periodic_irq_one |=> !periodic_irq_one)
    else $error("irq1 wide");
  valid_pulse_a: assert property (dispatch.vector_valid |=> !dispatch.vector_valid)
    else $error("valid wide");
  irq_dispatch_a: assert property (irq_idle_s |-> go_s)
    else $error("no dispatch");
  hold_follows_a: assert property (dispatch.vector_valid |-> ##[0:1] scan_hold)
    else $error("no hold");
  resume_stable_a: assert property (scan_hold && $past(scan_hold) |-> $stable(dispatch.resume_addr))
    else $error("resume moved");
  hold_release_a: assert property (scan_hold && routine_done |=> !scan_hold)
    else $error("hold stuck");
  conflict_quiet_a: assert property (clash_held_s |-> !periodic_irq_zero)
    else $error("timer zero fired in conflict");
endmodule // scan_timer_monitor
bind periodic_scan_interrupt_timer scan_timer_monitor #(.TWO_TIMERS(TWO_TIMERS), .TICK_DIV(TICK_DIV)) mon (
  .mclk(mclk), .rst(rst), .cfg(cfg), .routine_done(routine_done), .scan_hold(scan_hold),
  .dispatch(dispatch), .periodic_irq_zero(periodic_irq_zero), .periodic_irq_one(periodic_irq_one),
  .cfg_conflict(cfg_conflict));

/* File: tb/scan_cpu_model.sv */
// Scan and routine model of the CPU side
`timescale 1ns/10ps
module scan_cpu_model
  import scan_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  input wire logic scan_hold,
  output logic [15:0] ladder_program_addr,
  output logic routine_done
);
  logic [5:0] busy_reg;
  // ====
  // Scan address frozen while a routine runs
  always_ff @(posedge mclk) begin
    if (rst) begin
      ladder_program_addr <= 16'h0000;
      busy_reg <= 6'h00;
    end else if (scan_hold) begin
      busy_reg <= busy_reg + 6'h01;
    end else begin
      busy_reg <= 6'h00;
      ladder_program_addr <= ladder_program_addr + 16'h0001;
    end
  end
  assign routine_done = scan_hold && (busy_reg == (slow ? 6'h1e : 6'h03));
endmodule // scan_cpu_model

/* File: tb/tb.sv */
// Testbench for the periodic scan interrupt timer
`timescale 1ns/10ps
module tb import scan_timer_pkg::*;;
  logic mclk, rst, slow, fin, addr_done, hold, irq0, irq1, filt, conflict;
  logic [15:0] addr;
  logic hold_s, done_s, irq0_s, conflict_s;
  logic [15:0] addr_s;
  timer_cfg_s cfg;
  dispatch_s disp;
  int fails = 0;
  int tests_run = 0;
  always #5 mclk = ~mclk;
  periodic_scan_interrupt_timer #(.TWO_TIMERS(1'b1), .TICK_DIV(17'h00009)) uut (
    .mclk(mclk), .rst(rst), .cfg(cfg), .fast_input_zero(fin), .ladder_program_addr(addr),
    .routine_done(addr_done), .scan_hold(hold), .dispatch(disp), .periodic_irq_zero(irq0),
    .periodic_irq_one(irq1), .fast_input_zero_filtered(filt), .cfg_conflict(conflict));
  scan_cpu_model cpu (.mclk(mclk), .rst(rst), .slow(slow), .scan_hold(hold),
    .ladder_program_addr(addr), .routine_done(addr_done));
  periodic_scan_interrupt_timer #(.TWO_TIMERS(1'b0), .TICK_DIV(17'h00009)) uut_single (
    .mclk(mclk), .rst(rst), .cfg(cfg), .fast_input_zero(fin), .ladder_program_addr(addr_s),
    .routine_done(done_s), .scan_hold(hold_s), .dispatch(), .periodic_irq_zero(irq0_s),
    .periodic_irq_one(), .fast_input_zero_filtered(), .cfg_conflict(conflict_s));
  scan_cpu_model cpu_single (.mclk(mclk), .rst(rst), .slow(slow), .scan_hold(hold_s),
    .ladder_program_addr(addr_s), .routine_done(done_s));
  // ====
  // Shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_irq(input bit one, output int n);
    n = 0;
    do begin @(posedge mclk); #1; n++; end
    while ((one ? irq1 : irq0) !== 1'b1 && n < 30000);
    if (n >= 30000) begin fails++; give_verdict(); end
  endtask
  // ====
  // Scenarios
  task automatic t_period(input bit one, input logic [13:0] ms, input logic [15:0] exp);
    int n;
    @(posedge mclk);
    if (one) cfg.interval_one_ms <= ms;
    else cfg.interval_zero_ms <= ms;
    repeat (3) wait_irq(one, n);
    check(16'(n), exp);
    $display("period test done");
  endtask
  task automatic t_filter();
    @(posedge mclk);
    fin <= 1'b1;
    repeat (5) @(posedge mclk);
    #1 check({15'h0, filt}, 16'h0000);
    repeat (40) @(posedge mclk);
    #1 check({15'h0, filt}, 16'h0001);
    @(posedge mclk);
    fin <= 1'b0;
    $display("filter test done");
  endtask
  task automatic t_ext();
    int n = 0;
    logic [15:0] last;
    @(posedge mclk);
    cfg.periodic_zero_en <= 1'b0;
    cfg.interval_one_ms <= 14'h03e7;
    cfg.ext_irq_en <= 1'b1;
    slow <= 1'b1;
    repeat (60) @(posedge mclk);
    fin <= 1'b1;
    do begin
      last = addr;
      @(posedge mclk);
      #1;
      n++;
    end while (!(disp.vector_valid === 1'b1 && disp.vector === 2'h0) && n < 80);
    check(16'(n < 80), 16'h0001);
    check(disp.resume_addr, last);
    check({15'h0, hold}, 16'h0001);
    if (n >= 80) give_verdict();
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (hold !== 1'b0 && n < 60);
    check(16'(n < 60), 16'h0001);
    if (n >= 60) give_verdict();
    $display("external test done");
  endtask
  task automatic t_single();
    int n = 0;
    int hits = 0;
    @(posedge mclk);
    cfg.periodic_zero_en <= 1'b1;
    cfg.interval_zero_ms <= 14'h0005;
    repeat (2) @(posedge mclk);
    #1 check({15'h0, conflict_s}, 16'h0001);
    check({15'h0, conflict}, 16'h0000);
    repeat (120) begin
      @(posedge mclk);
      #1;
      if (irq0_s !== 1'b0) n++;
      if (irq0 === 1'b1) hits++;
    end
    check(16'(n), 16'h0000);
    check(16'(hits > 0), 16'h0001);
    $display("single timer test done");
  endtask
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    slow = 1'b0;
    fin = 1'b0;
    cfg = '{1'b1, 1'b1, 1'b0, 14'h0003, 14'h0006, 7'h02};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_period(1'b0, 14'h0003, 16'h0032);
    t_period(1'b1, 14'h0006, 16'h003c);
    t_period(1'b0, 14'h03e7, 16'h2706);
    t_filter();
    t_ext();
    t_single();
    give_verdict();
  end
endmodule // tb
